// ---- verilog/cst_pkg.sv ----
// Constants and types shared by the charger supervisor block
// How it works
// - Input overvoltage stops PWM, sets fault code, pulses fault on status.
// - Input below overvoltage exit clears that fault and charging resumes.
// - Input power-up sinks current; input good for 30 ms means good adapter.
// - Input drop in detection releases sink, pulses fault, status code 011.
// - After a bad adapter, wait one interval then redo detection.
// - Retry interval is at least 2 seconds.
// - Input under battery plus offset yet above minimum means sleep.
// - Input at power limit threshold reduces current, sets special flag.
// - Battery overvoltage stops PWM, sets fault code, pulses fault.
// - Battery below overvoltage exit clears fault and resumes charging.
// - Battery below short threshold charges with reduced short current.
// - Power-up detect variant: 262 ms timer after short mode decides absence.
// - Variants without power-up detect just regulate to default level.
// - Host mode termination: stop PWM, discharge 262 ms, sample battery.
// - Battery low after detect: absent, defaults restored, retry later.
// - Good adapter and battery start safety timer; host write starts watchdog.
// - Kick bit write restarts watchdog; device clears the bit itself.
// - Watchdog expiry restores defaults and returns to 15-minute mode.
// - Safety timer expiry stops charge, reports fault, 128 us pulse.
// - Only power-up clears faults; status frozen until host reads.
// - OTG variants offer boost mode; others only charge and high-Z.
// - High-impedance mode stops all charging and boosting.
// - With no host, run 15-minute mode on register defaults.
package cst_pkg;

  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int CLK_HZ = 40000000;
  localparam int TICK_US = 1;
  localparam int TICK_CYC = CLK_HZ / 1000000 * TICK_US;
  localparam int DEGLITCH_MS = 30;
  localparam int DETECT_MS = 262;
  localparam int INTERVAL_S = 2;
  localparam int WDOG_S = 32;
  localparam int SAFETY_MIN = 15;
  localparam int IRQ_PULSE_US = 128;
  localparam int DEGLITCH_TK = DEGLITCH_MS * 1000 / TICK_US;
  localparam int DETECT_TK = DETECT_MS * 1000 / TICK_US;
  localparam int INTERVAL_TK = INTERVAL_S * 1000000 / TICK_US;
  localparam int WDOG_TK = WDOG_S * 1000000 / TICK_US;
  localparam int SAFETY_TK = SAFETY_MIN * 60 * 1000000 / TICK_US;
  localparam int IRQ_PULSE_TK = IRQ_PULSE_US / TICK_US;
  localparam int TW = 30;

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  localparam logic [7:0] STATUS_ADDR = 8'h00;
  localparam logic [7:0] CONTROL_ADDR = 8'h01;
  localparam logic [7:0] SPECIAL_ADDR = 8'h05;
  localparam int SPECIAL_BIT = 4;
  localparam int KICK_BIT = 7;
  localparam int HIZ_BIT = 1;
  localparam int BOOST_BIT = 0;
  localparam logic [2:0] CODE_OK = 3'h0;
  localparam logic [2:0] CODE_IN_OVP = 3'h1;
  localparam logic [2:0] CODE_BAT_OVP = 3'h2;
  localparam logic [2:0] CODE_BAD_ADAPTER = 3'h3;
  localparam logic [2:0] CODE_SAFETY = 3'h4;
  localparam logic [2:0] CODE_NO_BATTERY = 3'h5;

  // ----------------------------------------
  // Types
  // ----------------------------------------
  typedef struct packed {
    logic in_ovp;
    logic in_ovp_exit;
    logic above_min;
    logic below_sleep;
    logic at_power_limit;
    logic bat_ovp;
    logic bat_ovp_exit;
    logic below_short;
    logic above_recharge;
    logic term_current;
  } cst_sense_t;

  typedef struct packed {
    logic pwm_on;
    logic sink_on;
    logic discharge_on;
    logic blocking_fet_on;
    logic short_current;
    logic reduce_current;
    logic use_defaults;
    logic boost_on;
  } cst_drive_t;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } cst_bus_t;

endpackage

// ---- verilog/cst_sync.sv ----
// Two-stage synchroniser for a bundle of comparator levels
`timescale 1ns/1ps
module cst_sync
  import cst_pkg::*;
(
  // Clock and reset
  input wire logic clock_in,
  input wire logic reset_n_in,
  // Levels
  input wire cst_sense_t async_in,
  output cst_sense_t sync_out
);

  typedef struct packed {
    cst_sense_t s1;
    cst_sense_t s2;
  } cst_sync_st_t;

  cst_sync_st_t st_q;
  cst_sync_st_t st_d;

  always_comb
  begin
    st_d.s1 = async_in;
    st_d.s2 = st_q.s1;
  end

  always_ff @(posedge clock_in)
  begin
    if (!reset_n_in)
      st_q <= '0;
    else
      st_q <= st_d;
  end

  assign sync_out = st_q.s2;

endmodule

// ---- verilog/cst_tick.sv ----
// Reference tick divider
`timescale 1ns/1ps
module cst_tick
  import cst_pkg::*;
(
  // Clock and reset
  input wire logic clock_in,
  input wire logic reset_n_in,
  // Tick
  output logic tick_out
);

  typedef struct packed {
    logic [7:0] cnt;
    logic tick;
  } cst_tick_st_t;

  localparam logic [7:0] TOP = 8'(TICK_CYC - 1);

  cst_tick_st_t st_q;
  cst_tick_st_t st_d;

  always_comb
  begin
    st_d = st_q;
    st_d.tick = 1'b0;
    if (st_q.cnt == TOP)
    begin
      st_d.cnt = 8'h00;
      st_d.tick = 1'b1;
    end
    else
      st_d.cnt = st_q.cnt + 8'h01;
  end

  always_ff @(posedge clock_in)
  begin
    if (!reset_n_in)
      st_q <= '0;
    else
      st_q <= st_d;
  end

  assign tick_out = st_q.tick;

endmodule

// ---- verilog/cst_supervisor.sv ----
// Charger supervisor: adapter checks, faults, battery detect, timers
//
// The register addresses and strobed register access were left to the implementer.
`timescale 1ns/1ps
module cst_supervisor
  import cst_pkg::*;
#(
  parameter logic HAS_POWERUP_DETECT = 1'b1,
  parameter logic HAS_OTG = 1'b1,
  parameter int SAFETY_TICKS = SAFETY_TK,
  parameter int WDOG_TICKS = WDOG_TK,
  parameter int INTERVAL_TICKS = INTERVAL_TK,
  parameter int DETECT_TICKS = DETECT_TK,
  parameter int DEGLITCH_TICKS = DEGLITCH_TK
)
(
  // Clock and reset
  input wire logic clock_in,
  input wire logic reset_n_in,
  // Analog comparators (asynchronous)
  input wire cst_sense_t sense_in,
  // Register port
  input wire logic [7:0] addr_in,
  input wire logic [7:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  output logic [7:0] rdata_out,
  // Power stage controls
  output cst_drive_t drive_out,
  output logic fault_pulse_out,
  output logic irq_pulse_out,
  output logic host_mode_out
);

  // ----------------------------------------
  // States and state record
  // ----------------------------------------
  typedef enum logic [7:0] {
    ST_DETECT  = 8'h01,
    ST_WAIT    = 8'h02,
    ST_CHARGE  = 8'h04,
    ST_BATCHK  = 8'h08,
    ST_DONE    = 8'h10,
    ST_HIZ     = 8'h20,
    ST_FAULT   = 8'h40,
    ST_SLEEP   = 8'h80
  } cst_state_t;

  typedef struct packed {
    cst_state_t state;
    logic [TW-1:0] phase_cnt;
    logic [TW-1:0] timer_cnt;
    logic host_mode;
    logic kick;
    logic hiz_req;
    logic boost_req;
    logic [2:0] code;
    logic code_held;
    logic special;
    logic pwr_detect_armed;
    logic was_short;
    logic fault_pulse;
    logic irq_pulse;
    logic [7:0] irq_cnt;
    logic use_defaults;
    logic halted;
    logic [7:0] rdata;
  } cst_st_t;

  localparam logic [TW-1:0] DEG_T = TW'(DEGLITCH_TICKS);
  localparam logic [TW-1:0] DET_T = TW'(DETECT_TICKS);
  localparam logic [TW-1:0] INT_T = TW'(INTERVAL_TICKS);
  localparam logic [TW-1:0] WD_T = TW'(WDOG_TICKS);
  localparam logic [TW-1:0] SAF_T = TW'(SAFETY_TICKS);
  localparam logic [7:0] IRQ_T = 8'(IRQ_PULSE_TK);

  cst_st_t st_q;
  cst_st_t st_d;
  cst_sense_t sense;
  logic tick;

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  cst_sync u_sync (
    .clock_in(clock_in),
    .reset_n_in(reset_n_in),
    .async_in(sense_in),
    .sync_out(sense)
  );

  cst_tick u_tick (
    .clock_in(clock_in),
    .reset_n_in(reset_n_in),
    .tick_out(tick)
  );

  // Fault code latch; held codes wait for a status read
  function automatic cst_st_t post_code(input cst_st_t s,
                                        input logic [2:0] c);
    cst_st_t r;
    r = s;
    if (!s.code_held)
    begin
      r.code = c;
      r.code_held = 1'b1;
    end
    r.fault_pulse = 1'b1;
    return r;
  endfunction

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb
  begin
    st_d = st_q;
    st_d.fault_pulse = 1'b0;
    st_d.rdata = 8'h00;

    // Count-based timing on the shared tick
    if (tick)
      st_d.phase_cnt = st_q.phase_cnt + TW'(1);

    // ----------------------------------------
    // Register reads; a status read releases the held code
    // ----------------------------------------
    if (rd_in)
    begin
      unique case (addr_in)
        STATUS_ADDR:
        begin
          st_d.rdata = {5'h00, st_q.code};
          st_d.code_held = 1'b0;
        end
        CONTROL_ADDR:
          st_d.rdata = {st_q.kick, 5'h00, st_q.hiz_req, st_q.boost_req};
        SPECIAL_ADDR:
          st_d.rdata = {3'h0, st_q.special, 4'h0};
        default:
          st_d.rdata = 8'h00;
      endcase
    end

    // ----------------------------------------
    // Watchdog / safety timer
    // ----------------------------------------
    if (tick)
      st_d.timer_cnt = st_q.timer_cnt + TW'(1);
    if (st_q.kick)
    begin
      st_d.timer_cnt = '0;
      st_d.kick = 1'b0;
    end
    if (wr_in)
    begin
      if (!st_q.host_mode)
        st_d.timer_cnt = '0;
      st_d.host_mode = 1'b1;
      st_d.use_defaults = 1'b0;
      if (addr_in == CONTROL_ADDR)
      begin
        st_d.kick = wdata_in[KICK_BIT];
        st_d.hiz_req = wdata_in[HIZ_BIT];
        st_d.boost_req = wdata_in[BOOST_BIT] & HAS_OTG;
      end
    end
    // A write in the expiry cycle defers expiry one cycle; a kick in it is still lost
    if (st_q.host_mode && st_q.timer_cnt >= WD_T && !wr_in)
    begin
      st_d.host_mode = 1'b0;
      st_d.use_defaults = 1'b1;
      st_d.timer_cnt = '0;
      st_d.boost_req = 1'b0;
      st_d.hiz_req = 1'b0;
    end

    // Power limit flag
    if (sense.at_power_limit)
      st_d.special = 1'b1;
    else if (rd_in && addr_in == SPECIAL_ADDR)
      st_d.special = 1'b0;

    // 128 us interrupt pulse
    if (st_q.irq_pulse && tick)
    begin
      st_d.irq_cnt = st_q.irq_cnt + 8'h01;
      if (st_q.irq_cnt == IRQ_T - 8'h01)
        st_d.irq_pulse = 1'b0;
    end

    unique case (st_q.state)
      ST_DETECT:
      begin
        // Synchroniser resets low; judge only after the first tick
        if (!sense.above_min && st_q.phase_cnt != '0)
        begin
          st_d = post_code(st_d, CODE_BAD_ADAPTER);
          st_d.state = ST_WAIT;
          st_d.phase_cnt = '0;
        end
        else if (st_q.phase_cnt >= DEG_T)
        begin
          st_d.state = ST_CHARGE;
          st_d.phase_cnt = '0;
          st_d.timer_cnt = '0;
        end
      end
      ST_WAIT:
        if (st_q.phase_cnt >= INT_T)
        begin
          st_d.state = ST_DETECT;
          st_d.phase_cnt = '0;
        end
      ST_CHARGE:
      begin
        // Faults outrank sleep and high-Z; detection steps come last
        if (sense.in_ovp)
        begin
          st_d = post_code(st_d, CODE_IN_OVP);
          st_d.state = ST_FAULT;
        end
        else if (sense.bat_ovp)
        begin
          st_d = post_code(st_d, CODE_BAT_OVP);
          st_d.state = ST_FAULT;
        end
        else if (!st_q.host_mode && st_q.timer_cnt >= SAF_T)
        begin
          st_d = post_code(st_d, CODE_SAFETY);
          st_d.irq_pulse = 1'b1;
          st_d.irq_cnt = 8'h00;
          st_d.halted = 1'b1;
          st_d.state = ST_DONE;
        end
        else if (sense.below_sleep && sense.above_min)
          st_d.state = ST_SLEEP;
        else if (st_q.hiz_req)
          st_d.state = ST_HIZ;
        else if (st_q.host_mode && sense.above_recharge &&
                 sense.term_current)
        begin
          st_d.state = ST_BATCHK;
          st_d.phase_cnt = '0;
        end
        else if (HAS_POWERUP_DETECT && st_q.pwr_detect_armed &&
                 !sense.below_short && st_q.was_short)
        begin
          st_d.was_short = 1'b0;
          st_d.phase_cnt = '0;
        end
        else if (HAS_POWERUP_DETECT && st_q.pwr_detect_armed &&
                 !st_q.was_short && st_q.phase_cnt >= DET_T)
        begin
          st_d.pwr_detect_armed = 1'b0;
          if (sense.above_recharge)
          begin
            st_d = post_code(st_d, CODE_NO_BATTERY);
            st_d.halted = 1'b1;
            st_d.state = ST_HIZ;
          end
        end
        if (!st_q.pwr_detect_armed || !HAS_POWERUP_DETECT)
          st_d.was_short = sense.below_short;
      end
      ST_BATCHK:
        // Absent battery drops host settings and waits to retry
        if (st_q.phase_cnt >= DET_T)
        begin
          st_d.phase_cnt = '0;
          if (sense.above_recharge)
            st_d.state = ST_DONE;
          else
          begin
            st_d.use_defaults = 1'b1;
            st_d.host_mode = 1'b0;
            st_d.state = ST_WAIT;
          end
        end
      ST_FAULT:
        // Live levels decide; the held code may name an older fault
        if (sense.in_ovp_exit && sense.bat_ovp_exit &&
            !sense.in_ovp && !sense.bat_ovp)
          st_d.state = ST_CHARGE;
      ST_SLEEP:
        if (!sense.below_sleep || !sense.above_min)
          st_d.state = ST_CHARGE;
      ST_HIZ:
        if (!st_q.hiz_req && !st_q.halted)
          st_d.state = ST_CHARGE;
      ST_DONE:
        // Safety expiry and a battery missing at power-up detect hold until power-up
        if (!sense.above_recharge && !st_q.halted)
          st_d.state = ST_CHARGE;
      default:
        st_d.state = ST_DETECT;
    endcase
  end

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  // Reset stands for input power-up, the only fault clear
  always_ff @(posedge clock_in)
  begin
    if (!reset_n_in)
    begin
      st_q <= '0;
      st_q.state <= ST_DETECT;
      st_q.use_defaults <= 1'b1;
      st_q.pwr_detect_armed <= 1'b1;
      st_q.was_short <= 1'b1;
    end
    else
      st_q <= st_d;
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  // Boost kept out of charge path; on only in the charge state
  always_comb
  begin
    drive_out = '0;
    drive_out.sink_on = (st_q.state == ST_DETECT);
    drive_out.pwm_on = (st_q.state == ST_CHARGE) && !st_q.boost_req;
    drive_out.blocking_fet_on = (st_q.state != ST_SLEEP) &&
                                (st_q.state != ST_HIZ);
    drive_out.discharge_on = (st_q.state == ST_BATCHK);
    // Current limits follow the synced levels, not the state
    drive_out.short_current = sense.below_short;
    drive_out.reduce_current = sense.at_power_limit;
    drive_out.use_defaults = st_q.use_defaults;
    drive_out.boost_on = st_q.boost_req && HAS_OTG &&
                         (st_q.state == ST_CHARGE);
  end

  assign rdata_out = st_q.rdata;
  assign fault_pulse_out = st_q.fault_pulse;
  assign irq_pulse_out = st_q.irq_pulse;
  assign host_mode_out = st_q.host_mode;

endmodule

// ---- tb/cst_host_model.sv ----
// Host processor model driving the register port
`timescale 1ns/1ps
module cst_host_model
  import cst_pkg::*;
(
  // Clock
  input wire logic clock_in,
  // Register port
  output logic [7:0] addr_out,
  output logic [7:0] wdata_out,
  output logic wr_out,
  output logic rd_out,
  input wire logic [7:0] rdata_in
);
  // ----------------------------------------
  // Bus cycles, entered right after an edge
  // ----------------------------------------
  initial
  begin
    addr_out = 8'h00;
    wdata_out = 8'h00;
    wr_out = 1'b0;
    rd_out = 1'b0;
  end

  // Any write leaves safety timer mode; bit 7 of a control register write kicks the watchdog
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    addr_out <= a;
    wdata_out <= d;
    wr_out <= 1'b1;
    @(posedge clock_in);
    wr_out <= 1'b0;
    wdata_out <= ~d;
    @(posedge clock_in);
  endtask

  // Status read frees the latched code
  task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
    addr_out <= a;
    rd_out <= 1'b1;
    @(posedge clock_in);
    rd_out <= 1'b0;
    addr_out <= ~a;
    // Data stand in the cycle after the strobe; take them at its end
    @(posedge clock_in);
    d = rdata_in;
  endtask
endmodule

// ---- tb/cst_supervisor_assertions.sv ----
// Port-level checker for the charger supervisor
`timescale 1ns/1ps
module cst_supervisor_assertions
  import cst_pkg::*;
#(
  parameter int WDOG_TICKS = WDOG_TK
)
(
  // Clock and reset
  input wire logic clock_in,
  input wire logic reset_n_in,
  // Inputs
  input wire cst_sense_t sense_in,
  input wire logic [7:0] addr_in,
  input wire logic [7:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  // Outputs
  input wire logic [7:0] rdata_out,
  input wire cst_drive_t drive_out,
  input wire logic fault_pulse_out,
  input wire logic irq_pulse_out,
  input wire logic host_mode_out
);
  localparam int IRQ_CYC = IRQ_PULSE_TK * TICK_CYC;
  localparam int WD_CYC = WDOG_TICKS * TICK_CYC;
  logic [31:0] quiet_q;
  logic [31:0] irq_q;

  default clocking cb @(posedge clock_in);
  endclocking
  default disable iff (!reset_n_in);

  // ----------------------------------------
  // Counters
  // ----------------------------------------
  // Tick phase is unknown, so timer bounds allow one tick of slack, two for the late watchdog bound
  always_ff @(posedge clock_in)
  begin
    // Only the entry write and kick writes restart the watchdog
    if (!reset_n_in || (wr_in && (!host_mode_out ||
        (addr_in == CONTROL_ADDR && wdata_in[KICK_BIT]))))
      quiet_q <= 32'h0;
    else
      quiet_q <= quiet_q + 32'h1;
    irq_q <= irq_pulse_out ? irq_q + 32'h1 : 32'h0;
  end

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  a_in_ovp_stop: assert property (
    sense_in.in_ovp [*6] |-> !drive_out.pwm_on)
    else $error("pwm on during input overvoltage");
  a_ovp_pulse: assert property (
    $rose(sense_in.in_ovp) && drive_out.pwm_on |-> ##[2:8] fault_pulse_out)
    else $error("no fault pulse on input overvoltage");
  a_fault_single: assert property (
    fault_pulse_out |=> !fault_pulse_out)
    else $error("fault pulse longer than one cycle");
  a_bat_ovp_stop: assert property (
    sense_in.bat_ovp [*6] |-> !drive_out.pwm_on)
    else $error("pwm on during battery overvoltage");
  a_sleep_off: assert property (
    (sense_in.below_sleep && sense_in.above_min) [*6]
    |-> !drive_out.pwm_on && !drive_out.blocking_fet_on)
    else $error("power stage on in sleep");
  a_short_rate: assert property (
    (sense_in.below_short && drive_out.pwm_on) [*4]
    |-> drive_out.short_current)
    else $error("short battery without reduced current");
  a_limit_reduce: assert property (
    (sense_in.at_power_limit && drive_out.pwm_on) [*4]
    |-> drive_out.reduce_current)
    else $error("no current reduction at power limit");
  a_write_host: assert property (
    wr_in |-> ##[1:2] host_mode_out)
    else $error("write did not enter host mode");
  a_wdog_early: assert property (
    $fell(host_mode_out) && !$fell(drive_out.discharge_on)
    |-> quiet_q >= WD_CYC - TICK_CYC)
    else $error("watchdog expired early");
  a_wdog_late: assert property (
    host_mode_out |-> quiet_q <= WD_CYC + 2 * TICK_CYC)
    else $error("watchdog expired late");
  a_irq_short: assert property (
    $fell(irq_pulse_out) |-> irq_q >= IRQ_CYC - TICK_CYC)
    else $error("interrupt pulse too short");
  a_irq_long: assert property (
    irq_pulse_out |-> irq_q <= IRQ_CYC + TICK_CYC)
    else $error("interrupt pulse too long");

  c_fault: cover property ($rose(fault_pulse_out));
  c_wdog: cover property ($fell(host_mode_out));
  c_irq: cover property ($fell(irq_pulse_out));
endmodule

bind cst_supervisor cst_supervisor_assertions #(
  .WDOG_TICKS(WDOG_TICKS)
) chk (
  .clock_in(clock_in), .reset_n_in(reset_n_in), .sense_in(sense_in),
  .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in),
  .rdata_out(rdata_out), .drive_out(drive_out),
  .fault_pulse_out(fault_pulse_out), .irq_pulse_out(irq_pulse_out),
  .host_mode_out(host_mode_out)
);

// ---- tb/charger_supervisor_timers_tb_top.sv ----
// Self-checking testbench for the charger supervisor
`timescale 1ns/1ps
module charger_supervisor_timers_tb_top
  import cst_pkg::*;
;
  // Shortened timers keep the run short
  localparam int SAF = 200;
  localparam int WD = 100;
  localparam int INTV = 50;
  localparam int DET = 20;
  localparam int DG = 10;
  localparam int LONG = (DG + 6) * TICK_CYC;
  logic clock_in = 1'b0;
  logic reset_n = 1'b0;
  cst_sense_t sense;
  logic [7:0] addr, wdata, rdata, d;
  logic wr, rd, fault, irq, host_mode;
  cst_drive_t drive;
  int err_total = 0;
  int checked = 0;
  int faults = 0;

  always #12.5 clock_in = ~clock_in;
  always @(posedge clock_in) if (fault === 1'b1) faults++;

  cst_host_model host (.clock_in(clock_in), .addr_out(addr),
    .wdata_out(wdata), .wr_out(wr), .rd_out(rd), .rdata_in(rdata));

  cst_supervisor #(.SAFETY_TICKS(SAF), .WDOG_TICKS(WD),
    .INTERVAL_TICKS(INTV), .DETECT_TICKS(DET), .DEGLITCH_TICKS(DG)) uut (
    .clock_in(clock_in), .reset_n_in(reset_n), .sense_in(sense),
    .addr_in(addr), .wdata_in(wdata), .wr_in(wr), .rd_in(rd),
    .rdata_out(rdata), .drive_out(drive), .fault_pulse_out(fault),
    .irq_pulse_out(irq), .host_mode_out(host_mode));

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  task automatic wrap_up();
    $display("checked=%0d err_total=%0d", checked, err_total);
    if (err_total == 0 && checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp)
    begin
      err_total++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  function automatic logic probe(input int sel);
    case (sel)
      0: return drive.pwm_on;
      1: return drive.sink_on;
      2: return irq;
      3: return host_mode;
      default: return drive.discharge_on;
    endcase
  endfunction

  // Bounded wait; running out ends the run
  task automatic wait_bit(input int sel, input logic v, input int lim);
    int n;
    n = 0;
    while (probe(sel) !== v && n < lim)
    begin
      @(posedge clock_in);
      n++;
    end
    check(8'(probe(sel)), 8'(v));
    if (probe(sel) !== v)
      wrap_up();
  endtask

  task automatic do_reset();
    reset_n <= 1'b0;
    repeat (6) @(posedge clock_in);
    reset_n <= 1'b1;
    @(posedge clock_in);
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  initial
  begin
    sense = '0;
    sense.in_ovp_exit = 1'b1;
    sense.bat_ovp_exit = 1'b1;
    sense.below_short = 1'b1;
    do_reset();
    wait_bit(1, 1'b1, 20);
    check(8'(drive.use_defaults), 8'h01);
    wait_bit(1, 1'b0, 200);
    host.rd_reg(STATUS_ADDR, d);
    check(d, {5'h0, CODE_BAD_ADAPTER});
    repeat ((INTV - 2) * TICK_CYC) @(posedge clock_in);
    check(8'(drive.sink_on), 8'h00);
    sense.above_min <= 1'b1;
    wait_bit(1, 1'b1, 5 * TICK_CYC);
    wait_bit(0, 1'b1, LONG);
    check(8'(drive.short_current), 8'h01);
    sense.below_short <= 1'b0;
    repeat ((DET + 4) * TICK_CYC) @(posedge clock_in);
    check(8'(drive.pwm_on), 8'h01);
    for (int i = 0; i < 2; i++)
    begin
      sense.in_ovp <= (i == 0);
      sense.bat_ovp <= (i == 1);
      sense.in_ovp_exit <= (i != 0);
      sense.bat_ovp_exit <= (i != 1);
      wait_bit(0, 1'b0, 40);
      host.rd_reg(STATUS_ADDR, d);
      check(d, {5'h0, i == 0 ? CODE_IN_OVP : CODE_BAT_OVP});
      sense.in_ovp <= 1'b0;
      sense.bat_ovp <= 1'b0;
      sense.in_ovp_exit <= 1'b1;
      sense.bat_ovp_exit <= 1'b1;
      wait_bit(0, 1'b1, LONG);
    end
    check(8'(faults), 8'h03);
    sense.below_sleep <= 1'b1;
    wait_bit(0, 1'b0, 40);
    repeat (8) @(posedge clock_in);
    check(8'(drive.blocking_fet_on), 8'h00);
    sense.below_sleep <= 1'b0;
    wait_bit(0, 1'b1, LONG);
    sense.at_power_limit <= 1'b1;
    repeat (8) @(posedge clock_in);
    check(8'(drive.reduce_current), 8'h01);
    sense.at_power_limit <= 1'b0;
    repeat (4) @(posedge clock_in);
    host.rd_reg(SPECIAL_ADDR, d);
    check(d & 8'h10, 8'h10);
    host.rd_reg(SPECIAL_ADDR, d);
    check(d & 8'h10, 8'h00);
    // Host mode: kick, high-Z, unmapped place
    host.wr_reg(CONTROL_ADDR, 8'h80);
    wait_bit(3, 1'b1, 4);
    host.rd_reg(CONTROL_ADDR, d);
    check(d & 8'h80, 8'h00);
    host.rd_reg(8'h3c, d);
    check(d, 8'h00);
    host.wr_reg(CONTROL_ADDR, 8'h02);
    wait_bit(0, 1'b0, 40);
    host.wr_reg(CONTROL_ADDR, 8'h80);
    wait_bit(0, 1'b1, LONG);
    host.wr_reg(CONTROL_ADDR, 8'h81);
    check(8'(drive.boost_on), 8'h01);
    check(8'(drive.pwm_on), 8'h00);
    host.wr_reg(CONTROL_ADDR, 8'h80);
    check(8'(drive.boost_on), 8'h00);
    // Termination with the battery still there ends in done
    sense.above_recharge <= 1'b1;
    sense.term_current <= 1'b1;
    wait_bit(4, 1'b1, 40);
    check(8'(drive.pwm_on), 8'h00);
    wait_bit(4, 1'b0, (DET + 4) * TICK_CYC);
    check(8'(drive.pwm_on), 8'h00);
    check(8'(host_mode), 8'h01);
    sense.above_recharge <= 1'b0;
    sense.term_current <= 1'b0;
    wait_bit(0, 1'b1, LONG);
    host.wr_reg(CONTROL_ADDR, 8'h80);
    repeat (3)
    begin
      repeat ((WD - 20) * TICK_CYC) @(posedge clock_in);
      host.wr_reg(CONTROL_ADDR, 8'h80);
    end
    check(8'(host_mode), 8'h01);
    wait_bit(3, 1'b0, (WD + 4) * TICK_CYC);
    check(8'(drive.use_defaults), 8'h01);
    wait_bit(2, 1'b1, (SAF + 4) * TICK_CYC);
    check(8'(drive.pwm_on), 8'h00);
    host.rd_reg(STATUS_ADDR, d);
    check(d, {5'h0, CODE_SAFETY});
    check(8'(faults), 8'h04);
    wait_bit(2, 1'b0, (IRQ_PULSE_TK + 4) * TICK_CYC);
    do_reset();
    host.rd_reg(STATUS_ADDR, d);
    check(d, 8'h00);
    wrap_up();
  end
endmodule
